// ---- src/pid_sched_pkg.sv ----
// Constants shared by the PID gain schedule supervisor.
`default_nettype none
package pid_sched_pkg;
   // Clock and control beat timing.
   localparam int CLK_PERIOD_NS   = 10;
   localparam int BEAT_TIME_NS    = 2_000_000;
   localparam int BEAT_CYCLES     = BEAT_TIME_NS / CLK_PERIOD_NS;
   localparam int BEAT_TIME_US    = BEAT_TIME_NS / 1000;
   // Hold time counts 10 ms units, loss time counts 100 ms units.
   localparam int HOLD_UNIT_US    = 10_000;
   localparam int LOSS_UNIT_US    = 100_000;
   localparam int HOLD_BEATS_UNIT = HOLD_UNIT_US / BEAT_TIME_US;
   localparam int LOSS_BEATS_UNIT = LOSS_UNIT_US / BEAT_TIME_US;
   // Widths of percent values (0.1 % units), gains, times and counters.
   localparam int PCT_W    = 10;
   localparam int GAIN_W   = 16;
   localparam int TIME_W   = 16;
   localparam int BEAT_CW  = 18;
   localparam int TIMER_W  = 21;
   localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
   // Gain set selection codes.
   localparam logic [1:0] MODE_FIXED    = 2'h0;
   localparam logic [1:0] MODE_TERMINAL = 2'h1;
   localparam logic [1:0] MODE_DEVIATE  = 2'h2;
   localparam logic [1:0] MODE_FREQ     = 2'h3;
   // Stop-state calculation codes.
   localparam logic STOP_SUSPEND = 1'b0;
   localparam logic STOP_COMPUTE = 1'b1;
   // Reset values.
   localparam logic [PCT_W-1:0]   PCT_RST   = 10'h000;
   localparam logic [GAIN_W-1:0]  GAIN_RST  = 16'h0000;
   localparam logic [TIMER_W-1:0] TIMER_RST = 21'h00_0000;
   localparam logic [BEAT_CW-1:0] BEAT_RST  = 18'h0_0000;
   // Regulator phases.
   typedef enum logic [1:0] {PH_IDLE, PH_HOLD, PH_REGULATE} phase_e;
endpackage : pid_sched_pkg
`default_nettype wire

// ---- src/pid_gain_schedule_supervisor.sv ----
// Gain scheduling, start hold, step limit and feedback loss supervisor.
//
// Contract
// - Four gain selection codes fixed/terminal/deviation/frequency.
// - Terminal inactive selects set one, active set two.
// - Deviation below lower threshold selects set one.
// - Deviation above upper threshold selects set two.
// - Between thresholds, gains interpolate linearly.
// - After start, hold initial value for hold time.
// - Run in 2 ms beats, clamp output step.
// - Feedback low past detection time raises fault.
// - Stop code 0 suspends, code 1 keeps computing.
// - Target and feedback are 0 to 100 percent.
`default_nettype none
module pid_gain_schedule_supervisor #(
   parameter int BEAT_CYCLES = pid_sched_pkg::BEAT_CYCLES // Cycles per beat.
) (
   input  wire logic        clk,                  // 100 MHz clock.
   input  wire logic        reset_n,              // Async reset, low.
   input  wire logic        run,                  // Drive running level.
   input  wire logic [1:0]  gain_mode,            // Gain selection code.
   input  wire logic        multi_function_input, // Gain switch pin.
   input  wire logic [9:0]  target,               // Target, 0.1 %.
   input  wire logic [9:0]  feedback,             // Feedback, 0.1 %.
   input  wire logic [9:0]  oper_freq,            // Frequency, 0.1 %.
   input  wire logic [9:0]  switch_dev_lo,        // Lower threshold.
   input  wire logic [9:0]  switch_dev_hi,        // Upper threshold.
   input  wire logic [15:0] prop_gain_set_one,    // Gain set one Kp.
   input  wire logic [15:0] integ_time_set_one,   // Gain set one Ti.
   input  wire logic [15:0] deriv_time_set_one,   // Gain set one Td.
   input  wire logic [15:0] prop_gain_set_two,    // Gain set two Kp.
   input  wire logic [15:0] integ_time_set_two,   // Gain set two Ti.
   input  wire logic [15:0] deriv_time_set_two,   // Gain set two Td.
   input  wire logic [9:0]  init_value,           // Initial output.
   input  wire logic [15:0] init_hold_time,       // Hold, 10 ms units.
   input  wire logic [9:0]  max_step,             // Largest step a beat.
   input  wire logic [9:0]  reg_output,           // Regulator result.
   input  wire logic [9:0]  loss_thresh,          // Loss level, 0 off.
   input  wire logic [15:0] loss_time,            // Loss, 100 ms units.
   input  wire logic        stop_calc,            // Stop-state code.
   input  wire logic        fault_clear,          // Fault acknowledge.
   output logic      [15:0] prop_gain_out,        // Active Kp.
   output logic      [15:0] integ_time_out,       // Active Ti.
   output logic      [15:0] deriv_time_out,       // Active Td.
   output logic      [9:0]  pid_out,              // Supervised output.
   output logic             calc_enable,          // Regulator may run.
   output logic             beat,                 // 2 ms beat pulse.
   output logic             feedback_loss_fault   // Latched fault.
);
   localparam int PW = pid_sched_pkg::PCT_W;
   localparam int GW = pid_sched_pkg::GAIN_W;
   localparam int TW = pid_sched_pkg::TIMER_W;

   logic [pid_sched_pkg::BEAT_CW-1:0] div_r;
   logic                              mfi_meta_r;
   logic                              mfi_sync_r;
   logic                              run_d_r;
   pid_sched_pkg::phase_e             phase_r;
   logic [TW-1:0]                     hold_cnt_r;
   logic [TW-1:0]                     loss_cnt_r;
   logic [PW-1:0]                     hold_val_r;
   logic [PW-1:0]                     sched_x;
   logic                              start;
   logic                              calc_nxt;
   logic [TW-1:0]                     hold_limit;
   logic [TW-1:0]                     loss_limit;
   logic                              loss_low;
   logic                              fault_set;

   // Linear blend of two gains by (x-lo)/(hi-lo), clamped at both ends.
   function automatic logic [GW-1:0] blend(
      input logic [GW-1:0] a, input logic [GW-1:0] b,
      input logic [PW-1:0] x, input logic [PW-1:0] lo,
      input logic [PW-1:0] hi);
      logic signed [33:0] diff;
      logic signed [33:0] res;
      diff = 34'(signed'({1'b0, b})) - 34'(signed'({1'b0, a}));
      res  = 34'(signed'({1'b0, a}));
      if (x < lo || hi <= lo) begin
         res = 34'(signed'({1'b0, a}));
      end else if (x > hi) begin
         res = 34'(signed'({1'b0, b}));
      end else begin
         res = res + (diff * signed'(34'(x - lo))) / signed'(34'(hi - lo));
      end
      return res[GW-1:0];
   endfunction : blend

   // Absolute difference of two percent values.
   function automatic logic [PW-1:0] absdiff(
      input logic [PW-1:0] a, input logic [PW-1:0] b);
      return (a > b) ? a - b : b - a;
   endfunction : absdiff

   // Beat divider; all regulation waits for this enable.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_r <= pid_sched_pkg::BEAT_RST;
         beat  <= 1'b0;
      end else if (div_r == pid_sched_pkg::BEAT_CW'(BEAT_CYCLES - 1)) begin
         div_r <= pid_sched_pkg::BEAT_RST;
         beat  <= 1'b1;
      end else begin
         div_r <= div_r + 1'b1;
         beat  <= 1'b0;
      end
   end

   // The terminal is a pin, so it is synchronised before any use.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mfi_meta_r <= 1'b0;
         mfi_sync_r <= 1'b0;
      end else begin
         mfi_meta_r <= multi_function_input;
         mfi_sync_r <= mfi_meta_r;
      end
   end

   // Deviation uses the normalised percent values directly.
   assign sched_x = (gain_mode == pid_sched_pkg::MODE_FREQ) ? oper_freq
                  : absdiff(target, feedback);

   // Gains are refreshed once a beat so they never change mid-step.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prop_gain_out  <= pid_sched_pkg::GAIN_RST;
         integ_time_out <= pid_sched_pkg::GAIN_RST;
         deriv_time_out <= pid_sched_pkg::GAIN_RST;
      end else if (beat) begin
         case (gain_mode)
            pid_sched_pkg::MODE_TERMINAL: begin
               prop_gain_out  <= mfi_sync_r ? prop_gain_set_two
                                            : prop_gain_set_one;
               integ_time_out <= mfi_sync_r ? integ_time_set_two
                                            : integ_time_set_one;
               deriv_time_out <= mfi_sync_r ? deriv_time_set_two
                                            : deriv_time_set_one;
            end
            pid_sched_pkg::MODE_DEVIATE, pid_sched_pkg::MODE_FREQ: begin
               prop_gain_out  <= blend(prop_gain_set_one, prop_gain_set_two,
                                       sched_x, switch_dev_lo, switch_dev_hi);
               integ_time_out <= blend(integ_time_set_one,
                                       integ_time_set_two, sched_x,
                                       switch_dev_lo, switch_dev_hi);
               deriv_time_out <= blend(deriv_time_set_one,
                                       deriv_time_set_two, sched_x,
                                       switch_dev_lo, switch_dev_hi);
            end
            default: begin
               prop_gain_out  <= prop_gain_set_one;
               integ_time_out <= integ_time_set_one;
               deriv_time_out <= deriv_time_set_one;
            end
         endcase
      end
   end

   // Start is the rising edge of run; hold length is counted in beats.
   assign start      = run && !run_d_r;
   assign hold_limit = TW'(init_hold_time) *
                       TW'(pid_sched_pkg::HOLD_BEATS_UNIT);

   // Phase sequencing: idle, hold at initial value, then regulate.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_d_r    <= 1'b0;
         phase_r    <= pid_sched_pkg::PH_IDLE;
         hold_cnt_r <= pid_sched_pkg::TIMER_RST;
         hold_val_r <= pid_sched_pkg::PCT_RST;
      end else begin
         run_d_r <= run;
         if (!run) begin
            phase_r <= pid_sched_pkg::PH_IDLE;
         end else if (start) begin
            phase_r    <= pid_sched_pkg::PH_HOLD;
            hold_cnt_r <= pid_sched_pkg::TIMER_RST;
            hold_val_r <= init_value;
         end else if (phase_r == pid_sched_pkg::PH_HOLD && beat) begin
            if (hold_cnt_r >= hold_limit) begin
               phase_r <= pid_sched_pkg::PH_REGULATE;
            end else begin
               hold_cnt_r <= hold_cnt_r + 1'b1;
            end
         end
      end
   end

   // Suspending while stopped keeps the integrator from winding up.
   assign calc_nxt = (phase_r == pid_sched_pkg::PH_REGULATE) ||
                     (phase_r == pid_sched_pkg::PH_IDLE &&
                      stop_calc == pid_sched_pkg::STOP_COMPUTE);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         calc_enable <= 1'b0;
      end else begin
         calc_enable <= calc_nxt;
      end
   end

   // Output: forced during hold, else moves at most max_step a beat.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pid_out <= pid_sched_pkg::PCT_RST;
      end else if (start) begin
         pid_out <= init_value;
      end else if (phase_r == pid_sched_pkg::PH_HOLD) begin
         pid_out <= hold_val_r;
      end else if (beat && calc_enable) begin
         if (reg_output > pid_out && reg_output - pid_out > max_step) begin
            pid_out <= pid_out + max_step;
         end else if (reg_output < pid_out &&
                      pid_out - reg_output > max_step) begin
            pid_out <= pid_out - max_step;
         end else begin
            pid_out <= reg_output;
         end
      end
   end

   // Loss timer in beats; a zero threshold disables the check.
   assign loss_limit = TW'(loss_time) * TW'(pid_sched_pkg::LOSS_BEATS_UNIT);
   assign loss_low   = (loss_thresh != pid_sched_pkg::PCT_RST) &&
                       (feedback < loss_thresh);
   assign fault_set  = beat && loss_low && (loss_cnt_r == loss_limit);

   // The timer stops one past the limit so a fault fires once per dropout.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         loss_cnt_r <= pid_sched_pkg::TIMER_RST;
      end else if (!loss_low) begin
         loss_cnt_r <= pid_sched_pkg::TIMER_RST;
      end else if (beat && loss_cnt_r <= loss_limit) begin
         loss_cnt_r <= loss_cnt_r + 1'b1;
      end
   end

   // Sticky fault; a new event in the clear cycle wins over the clear.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         feedback_loss_fault <= 1'b0;
      end else if (fault_set) begin
         feedback_loss_fault <= 1'b1;
      end else if (fault_clear) begin
         feedback_loss_fault <= 1'b0;
      end
   end

   // Checks run on clk and sleep in reset; start enters hold next cycle.
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence start_s;
      start;
   endsequence

   sequence hold_s;
      phase_r == pid_sched_pkg::PH_HOLD && pid_out == hold_val_r;
   endsequence

   start_hold_a: assert property (
      start_s |=> hold_s) else $error("Start did not enter hold.");
   hold_value_a: assert property (
      (phase_r == pid_sched_pkg::PH_HOLD && run) |=> pid_out == hold_val_r)
      else $error("Output left initial value during hold.");
   step_limit_a: assert property (
      (beat && calc_enable && !start &&
       phase_r != pid_sched_pkg::PH_HOLD)
      |=> absdiff(pid_out, $past(pid_out)) <= $past(max_step))
      else $error("Output step exceeded limit.");
   beat_gap_a: assert property (
      beat |=> !beat[*2]) else $error("Beat pulses too close.");
   gain_low_a: assert property (
      (beat && gain_mode == pid_sched_pkg::MODE_DEVIATE &&
       sched_x < switch_dev_lo) |=> prop_gain_out == $past(prop_gain_set_one))
      else $error("Low deviation did not select set one.");
   gain_high_a: assert property (
      (beat && gain_mode == pid_sched_pkg::MODE_DEVIATE &&
       switch_dev_lo < switch_dev_hi && sched_x > switch_dev_hi)
      |=> prop_gain_out == $past(prop_gain_set_two))
      else $error("High deviation did not select set two.");
   gain_term_a: assert property (
      (beat && gain_mode == pid_sched_pkg::MODE_TERMINAL)
      |=> integ_time_out == ($past(mfi_sync_r) ? $past(integ_time_set_two)
                                               : $past(integ_time_set_one)))
      else $error("Terminal selected wrong gain set.");
   suspend_a: assert property (
      (phase_r == pid_sched_pkg::PH_IDLE && stop_calc == 1'b0)
      |=> !calc_enable) else $error("Regulator computing while stopped.");
   timer_restart_a: assert property (
      !loss_low |=> loss_cnt_r == pid_sched_pkg::TIMER_RST)
      else $error("Loss timer not restarted.");
   fault_raise_a: assert property (
      fault_set |=> feedback_loss_fault ##1
      (feedback_loss_fault || $past(fault_clear)))
      else $error("Fault not latched.");
endmodule : pid_gain_schedule_supervisor
`default_nettype wire

// ---- tb/feedback_path_model.sv ----
// Behavioural model of the feedback sensor and the regulator result path.
`default_nettype none
module feedback_path_model (
   input  wire logic       clk,        // Control clock.
   input  wire logic       reset_n,    // Async reset, low.
   input  wire logic [9:0] fb_level,   // Process level to report.
   input  wire logic [9:0] cmd_level,  // Regulator result to present.
   output logic      [9:0] feedback,   // Sensor reading, 0.1 %.
   output logic      [9:0] reg_output  // Regulator result, 0.1 %.
);
   timeunit 1ns;
   timeprecision 1ps;
   // The sensor reports one clock late, like a sampled transducer.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         feedback   <= 10'h000;
         reg_output <= 10'h000;
      end else begin
         feedback   <= fb_level;
         reg_output <= cmd_level;
      end
   end
endmodule : feedback_path_model
`default_nettype wire

// ---- tb/test_pid_gain_schedule_supervisor.sv ----
// Self-checking testbench for the gain schedule supervisor.
`default_nettype none
module test_pid_gain_schedule_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, run, mfi, stop_calc, fault_clear, beat, calc_enable;
   logic [1:0] gain_mode;
   logic [9:0] target, feedback, oper_freq, init_value, max_step, reg_output;
   logic [9:0] loss_thresh, fb_level, cmd_level, pid_out;
   logic [15:0] loss_time, kp_out, ti_out, td_out;
   logic [15:0] kp_one, kp_two, hold_time;
   logic [9:0]  sw_lo, sw_hi;
   logic        fault;
   int errors, tests_run;
   logic [15:0] kp_exp [4] = '{16'h0064, 16'h012C, 16'h00C8, 16'h0096};
   logic [15:0] ti_exp [4] = '{16'h03E8, 16'h0190, 16'h02BC, 16'h0352};
   pid_gain_schedule_supervisor #(.BEAT_CYCLES(10))
      pid_gain_schedule_supervisor_inst (
      .clk(clk), .reset_n(reset_n), .run(run), .gain_mode(gain_mode),
      .multi_function_input(mfi), .target(target), .feedback(feedback),
      .oper_freq(oper_freq), .switch_dev_lo(sw_lo),
      .switch_dev_hi(sw_hi), .prop_gain_set_one(kp_one),
      .integ_time_set_one(16'h03E8), .deriv_time_set_one(16'h000A),
      .prop_gain_set_two(kp_two), .integ_time_set_two(16'h0190),
      .deriv_time_set_two(16'h0032), .init_value(init_value),
      .init_hold_time(hold_time), .max_step(max_step),
      .reg_output(reg_output), .loss_thresh(loss_thresh),
      .loss_time(loss_time), .stop_calc(stop_calc),
      .fault_clear(fault_clear), .prop_gain_out(kp_out),
      .integ_time_out(ti_out), .deriv_time_out(td_out), .pid_out(pid_out),
      .calc_enable(calc_enable), .beat(beat),
      .feedback_loss_fault(fault));
   feedback_path_model feedback_path_model_inst (
      .clk(clk), .reset_n(reset_n), .fb_level(fb_level),
      .cmd_level(cmd_level), .feedback(feedback), .reg_output(reg_output));
   // A 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts one comparison and reports a difference at once.
   task automatic check(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Waits for n beat pulses, then lets the updates of that beat land.
   task automatic beats(input int n);
      repeat (n) begin
         @(negedge clk);
         while (beat !== 1'b1) @(negedge clk);
      end
      @(negedge clk);
   endtask : beats
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // A hang is cut short well past the expected run length.
   initial begin
      #200_000;
      errors++;
      results();
   end
   // Main sequence; inputs change on the falling edge only.
   initial begin
      errors = 0;
      tests_run = 0;
      reset_n = 1'b0;
      run = 1'b0;
      mfi = 1'b1;
      stop_calc = 1'b0;
      fault_clear = 1'b0;
      gain_mode = 2'h0;
      target = 10'h2BC;
      fb_level = 10'h0C8;
      oper_freq = 10'h15E;
      init_value = 10'h064;
      max_step = 10'h032;
      cmd_level = 10'h3E8;
      loss_thresh = 10'h000;
      loss_time = 16'h0001;
      sw_lo = 10'h0C8;
      sw_hi = 10'h320;
      kp_one = 16'h0064;
      kp_two = 16'h012C;
      hold_time = 16'h0001;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      // Beat pulses come every ten clocks with the short simulation divider.
      begin
         int gap;
         gap = 1;
         beats(1);
         while (beat !== 1'b1) begin
            @(negedge clk);
            gap++;
         end
         check("beat_gap", 16'h000A, 16'(gap));
      end
      // Every selection code with deviation 50.0 % and frequency 35.0 %.
      for (int m = 0; m < 4; m++) begin
         gain_mode = m[1:0];
         beats(2);
         check("prop_gain_out", kp_exp[m], kp_out);
         check("integ_time_out", ti_exp[m], ti_out);
      end
      check("deriv_time_out", 16'h0014, td_out);
      gain_mode = pid_sched_pkg::MODE_TERMINAL;
      mfi = 1'b0;
      beats(2);
      check("prop_gain_out", 16'h0064, kp_out);
      gain_mode = pid_sched_pkg::MODE_DEVIATE;
      fb_level = 10'h28A;
      beats(2);
      check("prop_gain_out", 16'h0064, kp_out);
      target = 10'h384;
      fb_level = 10'h000;
      beats(2);
      check("prop_gain_out", 16'h012C, kp_out);
      // Falling blend: set one above set two, wider band, deviation 90.0 %.
      sw_hi = 10'h3E8;
      kp_one = 16'h012C;
      kp_two = 16'h0064;
      beats(2);
      check("prop_gain_out", 16'h007D, kp_out);
      sw_hi = 10'h320;
      kp_one = 16'h0064;
      kp_two = 16'h012C;
      $display("Test gain selection done");
      // Start: hold six beats at the initial value, then limited steps.
      run = 1'b1;
      beats(3);
      check("pid_out", 16'h0064, {6'h00, pid_out});
      check("calc_enable", 16'h0000, {15'h0000, calc_enable});
      beats(6);
      check("calc_enable", 16'h0001, {15'h0000, calc_enable});
      beats(1);
      target[0] = 1'b0;
      begin
         logic [9:0] prev;
         prev = pid_out;
         beats(1);
         check("pid_step", 16'h0032, 16'(pid_out - prev));
      end
      beats(20);
      check("pid_out", 16'h03E8, {6'h00, pid_out});
      $display("Test start hold and step limit done");
      // Stopped with suspend code: output frozen; compute code: it moves.
      run = 1'b0;
      cmd_level = 10'h000;
      beats(3);
      check("calc_enable", 16'h0000, {15'h0000, calc_enable});
      check("pid_out", 16'h03E8, {6'h00, pid_out});
      stop_calc = pid_sched_pkg::STOP_COMPUTE;
      beats(3);
      check("pid_moved", 16'h0001, {15'h0000, pid_out < 10'h3E8});
      $display("Test stop calculation done");
      // Feedback loss: 51 low beats needed, recovery restarts the count.
      loss_thresh = 10'h064;
      fb_level = 10'h032;
      beats(40);
      check("fault", 16'h0000, {15'h0000, fault});
      fb_level = 10'h1F4;
      beats(2);
      fb_level = 10'h032;
      beats(40);
      check("fault", 16'h0000, {15'h0000, fault});
      beats(15);
      check("fault", 16'h0001, {15'h0000, fault});
      fault_clear = 1'b1;
      @(negedge clk);
      fault_clear = 1'b0;
      beats(5);
      check("fault", 16'h0000, {15'h0000, fault});
      loss_thresh = 10'h000;
      fb_level = 10'h1F4;
      beats(2);
      fb_level = 10'h000;
      beats(60);
      check("fault", 16'h0000, {15'h0000, fault});
      $display("Test feedback loss done");
      results();
   end
endmodule : test_pid_gain_schedule_supervisor
`default_nettype wire
